// ---- rtl/smbmsi_defines.svh ----
// Timing and field constants for the two-wire serial bus interface
`ifndef SMBMSI_DEFINES_SVH
`define SMBMSI_DEFINES_SVH

`define SMB_CLK_NS        25
`define SMB_SRC_NS        250
`define SMB_SRC_CYC       ((`SMB_SRC_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_LOW_CYC       (`SMB_SRC_CYC)
`define SMB_HIGH_CYC      (`SMB_SRC_CYC)
`define SMB_HOLD_NS       50
`define SMB_HOLD_CYC      ((`SMB_HOLD_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_FREE_PERIODS  10
`define SMB_FREE_CYC      (`SMB_FREE_PERIODS * `SMB_SRC_CYC + 1)
`define SMB_LAST_DATA_BIT 4'h7
`define SMB_ACK_BIT       4'h8
`define SMB_DIR_BIT       0
`define SMB_CNT_MAX       8'hff

`endif

// ---- rtl/smbmsi_pkg.sv ----
// Types shared by the two-wire serial bus interface
package smbmsi_pkg;

  typedef enum logic [2:0] {
    CMD_START = 3'b000,
    CMD_WRITE = 3'b001,
    CMD_READ  = 3'b010,
    CMD_ACK   = 3'b011,
    CMD_STOP  = 3'b100
  } smbmsi_op_e;

  typedef enum logic [1:0] {
    EV_TX_DONE = 2'b00,
    EV_RX_BYTE = 2'b01,
    EV_STOP    = 2'b10
  } smbmsi_ev_e;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_WAIT_FREE = 4'b0001,
    ST_START     = 4'b0010,
    ST_LOW       = 4'b0011,
    ST_HIGH      = 4'b0100,
    ST_REPORT    = 4'b0101,
    ST_WAIT_CMD  = 4'b0110,
    ST_STOP_LOW  = 4'b0111,
    ST_STOP_HIGH = 4'b1000
  } smbmsi_state_e;

  typedef struct packed {
    logic enable;
    logic slave_inhibit;
    logic bus_free_timeout_enable;
  } smbmsi_cfg_s;

  typedef struct packed {
    smbmsi_op_e op;
    logic [7:0] data;
    logic       ack;
  } smbmsi_cmd_s;

  typedef struct packed {
    smbmsi_ev_e kind;
    logic [7:0] data;
    logic       ack_rcvd;
    logic       addr_phase;
    logic       arb_lost;
    logic       as_master;
  } smbmsi_evt_s;

  typedef struct packed {
    logic master;
    logic bus_busy;
    logic slave_active;
    logic arb_lost;
  } smbmsi_stat_s;

endpackage

// ---- rtl/smbmsi_core.sv ----
// Byte-level master/slave engine for a shared open-drain two-wire bus
`timescale 1ns/1ps
`default_nettype none
`include "smbmsi_defines.svh"

module smbmsi_core
  import smbmsi_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         scl_in,
  output logic              scl_out,
  output logic              scl_oe_n,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe_n,
  input  wire smbmsi_cfg_s  cfg,
  input  wire logic         cmd_valid,
  input  wire smbmsi_cmd_s  cmd,
  output logic              cmd_ready,
  output logic              evt_valid,
  output smbmsi_evt_s       evt,
  input  wire logic         evt_ready,
  output smbmsi_stat_s      status
);

  logic          scl_m, scl_s, scl_p;
  logic          sda_m, sda_s, sda_p;
  logic          start_det, stop_det, scl_rise, scl_fall;
  logic          bus_busy;
  logic [7:0]    free_cnt;
  smbmsi_state_e state, rep_next;
  logic [7:0]    cnt;
  logic [3:0]    bitn;
  logic [7:0]    serial_bus_data_reg;
  logic [7:0]    pend_addr;
  logic          start_pend, master, tx_role, slave_act, slave_inh;
  logic          addr_phase, arb_lost, ack_low, ack_rcvd;
  smbmsi_evt_s   ev;
  smbmsi_evt_s   spare;
  logic          spare_v;
  logic          push, pop, sample_now, bit_end, take;

  // Data level to pull for the current bit: zero means release
  function automatic logic drive_low(input logic tx, input logic [3:0] b,
                                     input logic msb, input logic ackl);
    if (b == `SMB_ACK_BIT) begin
      drive_low = tx ? 1'b0 : ackl;
    end else begin
      drive_low = tx ? ~msb : 1'b0;
    end
  endfunction

  // Event word built from the byte engine's state
  function automatic smbmsi_evt_s mk_evt(input smbmsi_ev_e k, input logic [7:0] d,
                                         input logic a, input logic ap,
                                         input logic al, input logic m);
    mk_evt = '{kind: k, data: d, ack_rcvd: a, addr_phase: ap, arb_lost: al, as_master: m};
  endfunction

  // Two-flop synchronisers plus a delay stage; the second and third stages feed logic
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // Bus conditions seen on the synchronised lines
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;
  assign scl_rise  = scl_s & ~scl_p;
  assign scl_fall  = ~scl_s & scl_p;

  // Master paces bits by counters, slave by the bus clock edges
  assign sample_now = master ? (state == ST_HIGH && scl_s && cnt == 8'h00)
                             : (state == ST_LOW && scl_rise);
  assign bit_end    = (state == ST_HIGH) &&
                      (master ? (scl_s && cnt == 8'(`SMB_HIGH_CYC - 1)) : scl_fall);
  assign take       = cmd_ready & cmd_valid;
  assign push       = (state == ST_REPORT) & ~spare_v;

  // Busy between START and STOP, or until the free timeout expires
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_busy <= 1'b0;
      free_cnt <= 8'h00;
    end else begin
      if (scl_s && sda_s && cfg.bus_free_timeout_enable) begin
        free_cnt <= (free_cnt == `SMB_CNT_MAX) ? free_cnt : free_cnt + 8'h01;
      end else begin
        free_cnt <= 8'h00;
      end
      if (start_det) begin
        bus_busy <= 1'b1;
      end else if (stop_det) begin
        bus_busy <= 1'b0;
      end else if (free_cnt >= 8'(`SMB_FREE_CYC)) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // Byte engine; lines are only ever pulled low or released
  always_ff @(posedge ref_clk) begin
    if (reset || !cfg.enable) begin
      state      <= ST_IDLE;
      rep_next   <= ST_IDLE;
      cnt        <= 8'h00;
      bitn       <= 4'h0;
      serial_bus_data_reg <= 8'h00;
      pend_addr  <= 8'h00;
      start_pend <= 1'b0;
      master     <= 1'b0;
      tx_role    <= 1'b0;
      slave_act  <= 1'b0;
      slave_inh  <= 1'b0;
      addr_phase <= 1'b0;
      arb_lost   <= 1'b0;
      ack_low    <= 1'b0;
      ack_rcvd   <= 1'b0;
      ev         <= '0;
      cmd_ready  <= 1'b0;
      scl_oe_n   <= 1'b1;
      sda_oe_n   <= 1'b1;
    end else if (!master && start_det) begin
      // Any START by another master: receive the address as a slave
      state      <= ST_LOW;
      cnt        <= 8'h00;
      bitn       <= 4'h0;
      tx_role    <= 1'b0;
      addr_phase <= 1'b1;
      arb_lost   <= 1'b0;
      slave_act  <= 1'b1;
      slave_inh  <= cfg.slave_inhibit;
      cmd_ready  <= 1'b0;
      scl_oe_n   <= 1'b1;
      sda_oe_n   <= 1'b1;
    end else if (!master && stop_det && slave_act) begin
      ev         <= mk_evt(EV_STOP, serial_bus_data_reg, ack_rcvd, 1'b0, arb_lost, 1'b0);
      slave_act  <= 1'b0;
      state      <= ST_REPORT;
      rep_next   <= ST_IDLE;
      cmd_ready  <= 1'b0;
      sda_oe_n   <= 1'b1;
    end else begin
      // Shared sampling of each bit on clock high
      if (sample_now) begin
        if (bitn == `SMB_ACK_BIT) begin
          ack_rcvd <= ~sda_s;
        end else begin
          serial_bus_data_reg <= {serial_bus_data_reg[6:0], sda_s};
          if (tx_role && master && serial_bus_data_reg[7] && !sda_s) begin
            // Lost arbitration: keep listening for the rest of the byte
            master    <= 1'b0;
            arb_lost  <= 1'b1;
            tx_role   <= 1'b0;
            scl_oe_n  <= 1'b1;
            slave_act <= 1'b1;
            slave_inh <= cfg.slave_inhibit;
          end
        end
      end
      case (state)
        ST_IDLE: begin
          scl_oe_n <= 1'b1;
          sda_oe_n <= 1'b1;
          if (start_pend) begin
            cmd_ready <= 1'b0;
            state     <= ST_WAIT_FREE;
          end else if (take) begin
            cmd_ready <= 1'b0;
            if (cmd.op == CMD_START) begin
              start_pend <= 1'b1;
              pend_addr  <= cmd.data;
            end
          end else begin
            cmd_ready <= 1'b1;
          end
        end
        ST_WAIT_FREE: begin
          if (!bus_busy && scl_s && sda_s) begin
            sda_oe_n   <= 1'b0;
            master     <= 1'b1;
            start_pend <= 1'b0;
            serial_bus_data_reg <= pend_addr;
            cnt        <= 8'h00;
            state      <= ST_START;
          end
        end
        ST_START: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(`SMB_HIGH_CYC - 1)) begin
            scl_oe_n   <= 1'b0;
            cnt        <= 8'h00;
            bitn       <= 4'h0;
            tx_role    <= 1'b1;
            addr_phase <= 1'b1;
            arb_lost   <= 1'b0;
            state      <= ST_LOW;
          end
        end
        ST_LOW: begin
          cnt <= (cnt == `SMB_CNT_MAX) ? cnt : cnt + 8'h01;
          if (cnt == 8'(`SMB_HOLD_CYC)) begin
            sda_oe_n <= ~drive_low(tx_role, bitn, serial_bus_data_reg[7], ack_low);
          end
          if (master && cnt == 8'(`SMB_LOW_CYC - 1)) begin
            scl_oe_n <= 1'b1;
            cnt      <= 8'h00;
            state    <= ST_HIGH;
          end else if (!master && scl_rise) begin
            scl_oe_n <= 1'b1;
            state    <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // Count only once the line is really high
          if (master && scl_s) begin
            cnt <= cnt + 8'h01;
          end
          if (bit_end) begin
            cnt <= 8'h00;
            if (bitn == `SMB_LAST_DATA_BIT) begin
              if (tx_role) begin
                scl_oe_n <= ~master;
                bitn     <= `SMB_ACK_BIT;
                state    <= ST_LOW;
              end else if (!master && slave_inh && addr_phase) begin
                // Inhibited slave refuses every address silently
                ack_low   <= 1'b0;
                slave_act <= 1'b0;
                bitn      <= `SMB_ACK_BIT;
                state     <= ST_LOW;
              end else begin
                // Hold the clock low so software picks the acknowledge
                scl_oe_n <= 1'b0;
                ev       <= mk_evt(EV_RX_BYTE, serial_bus_data_reg, ack_rcvd,
                                   addr_phase, arb_lost, master);
                rep_next <= ST_WAIT_CMD;
                state    <= ST_REPORT;
              end
            end else if (bitn == `SMB_ACK_BIT) begin
              if (tx_role) begin
                scl_oe_n <= 1'b0;
                ev       <= mk_evt(EV_TX_DONE, serial_bus_data_reg, ack_rcvd,
                                   addr_phase, arb_lost, master);
                rep_next <= (!master && !ack_rcvd) ? ST_IDLE : ST_WAIT_CMD;
                state    <= ST_REPORT;
              end else if (!master && !ack_low) begin
                slave_act <= 1'b0;
                scl_oe_n  <= 1'b1;
                state     <= ST_IDLE;
              end else begin
                scl_oe_n   <= 1'b0;
                addr_phase <= 1'b0;
                cmd_ready  <= 1'b1;
                state      <= ST_WAIT_CMD;
              end
            end else begin
              scl_oe_n <= ~master;
              bitn     <= bitn + 4'h1;
              state    <= ST_LOW;
            end
          end
        end
        ST_REPORT: begin
          // A full buffer stalls here, with the clock held low for byte events
          if (!spare_v) begin
            state      <= rep_next;
            addr_phase <= 1'b0;
            cmd_ready  <= (rep_next == ST_WAIT_CMD);
            if (rep_next == ST_IDLE) begin
              slave_act <= 1'b0;
            end
          end
        end
        ST_WAIT_CMD: begin
          if (take) begin
            cmd_ready <= 1'b0;
            cnt       <= 8'h00;
            case (cmd.op)
              CMD_WRITE: begin
                serial_bus_data_reg <= cmd.data;
                tx_role  <= 1'b1;
                bitn     <= 4'h0;
                scl_oe_n <= ~master;
                state    <= ST_LOW;
              end
              CMD_READ: begin
                tx_role  <= 1'b0;
                bitn     <= 4'h0;
                scl_oe_n <= ~master;
                state    <= ST_LOW;
              end
              CMD_ACK: begin
                ack_low  <= cmd.ack;
                tx_role  <= 1'b0;
                bitn     <= `SMB_ACK_BIT;
                scl_oe_n <= ~master;
                state    <= ST_LOW;
              end
              default: begin
                // STOP, or START taken as STOP then a fresh START
                if (master) begin
                  start_pend <= (cmd.op == CMD_START);
                  pend_addr  <= cmd.data;
                  state      <= ST_STOP_LOW;
                end else begin
                  cmd_ready <= 1'b1;
                end
              end
            endcase
          end
        end
        ST_STOP_LOW: begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(`SMB_HOLD_CYC)) begin
            sda_oe_n <= 1'b0;
          end
          if (cnt == 8'(`SMB_LOW_CYC - 1)) begin
            scl_oe_n <= 1'b1;
            cnt      <= 8'h00;
            state    <= ST_STOP_HIGH;
          end
        end
        ST_STOP_HIGH: begin
          if (scl_s) begin
            cnt <= cnt + 8'h01;
          end
          if (scl_s && cnt == 8'(`SMB_HIGH_CYC - 1)) begin
            sda_oe_n <= 1'b1;
            master   <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Two-entry event buffer: output stage plus one spare
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      evt_valid <= 1'b0;
      evt       <= '0;
      spare_v   <= 1'b0;
      spare     <= '0;
    end else if (pop) begin
      if (spare_v) begin
        evt     <= spare;
        spare   <= ev;
        spare_v <= push;
      end else begin
        evt       <= ev;
        evt_valid <= push;
      end
    end else if (!evt_valid) begin
      evt       <= ev;
      evt_valid <= push;
    end else if (push) begin
      spare   <= ev;
      spare_v <= 1'b1;
    end
  end
  assign pop = evt_valid & evt_ready;

  // Status and the constant-low open-drain data values
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status  <= '0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      status  <= '{master: master, bus_busy: bus_busy, slave_active: slave_act,
                   arb_lost: arb_lost};
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- sim/smbmsi_monitor.sv ----
// Checker of bus framing and handshakes at the engine's ports
`timescale 1ns/1ps
`default_nettype none

module smbmsi_monitor
  import smbmsi_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         reset,
  input wire logic         scl_in,
  input wire logic         scl_out,
  input wire logic         sda_out,
  input wire logic         scl_oe_n,
  input wire logic         sda_oe_n,
  input wire logic         cmd_valid,
  input wire logic         cmd_ready,
  input wire smbmsi_cmd_s  cmd,
  input wire logic         evt_valid,
  input wire smbmsi_evt_s  evt,
  input wire logic         evt_ready,
  input wire smbmsi_stat_s status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Frame edges made by the engine while the clock line is high
  sequence s_start;
    $fell(sda_oe_n) && scl_in && scl_oe_n;
  endsequence
  sequence s_stop;
    $rose(sda_oe_n) && scl_in && scl_oe_n;
  endsequence

  property p_no_high;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  property p_start;
    s_start |-> scl_oe_n [*8] ##[1:6] $fell(scl_oe_n);
  endproperty
  property p_stop;
    s_stop |-> (scl_oe_n && sda_oe_n) [*8];
  endproperty
  // Low phase of at least ten cycles bounds the bit rate; a slave may stretch it longer
  property p_scl_low;
    $fell(scl_oe_n) && status.master |-> !scl_oe_n [*8] ##1 !scl_oe_n [*2];
  endproperty
  // High is counted from the real line, so a stretch delays it
  property p_scl_high;
    $rose(scl_in) && scl_oe_n && status.master |-> scl_oe_n [*8];
  endproperty
  property p_evt_hold;
    evt_valid && !evt_ready |=> evt_valid && $stable(evt);
  endproperty
  // A slave ignores STOP and START and keeps ready up
  property p_cmd_drop;
    cmd_valid && cmd_ready &&
      !(status.slave_active && (cmd.op == CMD_STOP || cmd.op == CMD_START)) |=> !cmd_ready;
  endproperty
  property p_evt_stretch;
    $rose(evt_valid) && evt.kind != EV_STOP |-> !scl_oe_n;
  endproperty

  a_no_high: assert property (p_no_high)
    else $error("bus line driven high");
  a_start: assert property (p_start)
    else $error("start not followed by clock low");
  a_stop: assert property (p_stop)
    else $error("bus pulled right after stop");
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  a_evt_hold: assert property (p_evt_hold)
    else $error("event changed before taken");
  a_cmd_drop: assert property (p_cmd_drop)
    else $error("command ready held after take");
  a_evt_stretch: assert property (p_evt_stretch)
    else $error("byte event without clock held low");
endmodule

bind smbmsi_core smbmsi_monitor u_smbmsi_monitor (
  .ref_clk, .reset, .scl_in, .scl_out, .sda_out, .scl_oe_n, .sda_oe_n,
  .cmd_valid, .cmd_ready, .cmd, .evt_valid, .evt, .evt_ready, .status
);

`default_nettype wire

// ---- sim/smbmsi_partner.sv ----
// Behavioural slave on the far side of the two-wire bus
`timescale 1ns/1ps
`default_nettype none

module smbmsi_partner (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  input  wire logic [7:0] rd_byte,
  input  wire logic [31:0] stretch_ns,
  output logic            scl_rel,
  output logic            sda_rel,
  output logic [7:0]      got_addr,
  output logic [7:0]      got_data,
  output logic            got_mack,
  output logic [3:0]      n_stop
);
  logic [7:0] b;
  int         i;

  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    n_stop  = 4'h0;
  end

  // Stop aborts any transfer and lets both pulled-up lines float
  always @(posedge sda) if (scl === 1'b1) begin
    disable xfer;
    sda_rel = 1'b1;
    scl_rel = 1'b1;
    n_stop  = n_stop + 4'h1;
  end

  // Byte in, sampled on clock rise, first bit most significant
  task automatic rx(output logic [7:0] v);
    for (int k = 0; k < 8; k++) begin
      @(posedge scl) v = {v[6:0], sda};
      @(negedge scl);
    end
  endtask

  // Acknowledge slot; data changes only after the hold time
  task automatic ack_slot;
    #60 sda_rel = ~ack_en;
    scl_rel = 1'b0;
    #(stretch_ns);
    scl_rel = 1'b1;
    @(negedge scl) #60;
  endtask

  always begin : xfer
    @(negedge sda iff scl === 1'b1);
    rx(b);
    got_addr = b;
    ack_slot;
    if (b[0] && ack_en) begin
      do begin
        for (i = 7; i >= 0; i--) begin
          sda_rel = rd_byte[i];
          @(negedge scl) #60;
        end
        sda_rel = 1'b1;
        @(posedge scl) got_mack = sda;
        @(negedge scl) #60;
      end while (got_mack == 1'b0);
    end else begin
      sda_rel = 1'b1;
      forever begin
        rx(b);
        got_data = b;
        ack_slot;
        sda_rel = 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the two-wire bus engine
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import smbmsi_pkg::*;
  logic         ref_clk;
  logic         reset;
  logic         cmd_valid;
  logic         evt_ready;
  logic         ack_en;
  logic         scl_out;
  logic         sda_out;
  logic         scl_oe_n;
  logic         sda_oe_n;
  logic         cmd_ready;
  logic         evt_valid;
  logic         p_scl_rel;
  logic         p_sda_rel;
  logic         got_mack;
  logic [7:0]   rd_byte;
  logic [7:0]   got_addr;
  logic [7:0]   got_data;
  logic [3:0]   n_stop;
  int           stretch_ns;
  int           n_fail;
  int           samples_checked;
  realtime      t_last;
  realtime      t_min;
  smbmsi_cfg_s  cfg;
  smbmsi_cmd_s  cmd;
  smbmsi_evt_s  evt;
  smbmsi_evt_s  e;
  smbmsi_stat_s status;
  wire logic    scl;
  wire logic    sda;

  // Pulled-up wires: low if any party pulls
  assign scl = (scl_oe_n !== 1'b0) && p_scl_rel;
  assign sda = (sda_oe_n !== 1'b0) && p_sda_rel;

  smbmsi_core u_smbmsi_core (
    .ref_clk, .reset, .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda),
    .sda_out, .sda_oe_n, .cfg, .cmd_valid, .cmd, .cmd_ready, .evt_valid,
    .evt, .evt_ready, .status
  );
  smbmsi_partner u_smbmsi_partner (
    .scl, .sda, .ack_en, .rd_byte, .stretch_ns, .scl_rel(p_scl_rel),
    .sda_rel(p_sda_rel), .got_addr, .got_data, .got_mack, .n_stop
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Shortest clock-rise spacing seen after reset
  always @(posedge scl) if (reset === 1'b0) begin
    if ($realtime - t_last < t_min) t_min = $realtime - t_last;
    t_last = $realtime;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Command held until a negedge shows ready, so the edge between takes it;
  // one idle edge follows so back-to-back calls never re-raise valid at once
  task automatic send(input smbmsi_op_e op, input logic [7:0] d, input logic a);
    int k;
    cmd_valid = 1'b1;
    cmd = '{op, d, a};
    for (k = 0; k < 4000 && cmd_ready !== 1'b1; k++) @(negedge ref_clk);
    if (k == 4000) begin n_fail++; results; end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    @(negedge ref_clk);
  endtask

  // Event taken after an optional stall of the consumer
  task automatic get(input int stall);
    int k;
    for (k = 0; k < 4000 && evt_valid !== 1'b1; k++) @(negedge ref_clk);
    if (k == 4000) begin n_fail++; results; end
    repeat (stall) @(negedge ref_clk);
    e = evt;
    evt_ready = 1'b1;
    @(negedge ref_clk);
    evt_ready = 1'b0;
  endtask

  task automatic stop_bus;
    int         k;
    logic [3:0] n0;
    n0 = n_stop;
    send(CMD_STOP, 8'h00, 1'b0);
    for (k = 0; k < 400 && !(scl && sda); k++) @(negedge ref_clk);
    if (k == 400) n_fail++;
    repeat (6) @(negedge ref_clk);
    check(n_stop, n0 + 4'h1);
    check({scl_oe_n, sda_oe_n, status.bus_busy, status.master, status.slave_active}, 5'b11000);
  endtask

  // Engine disable releases the lines and withdraws ready until enabled again
  task automatic t_disable;
    cfg.enable = 1'b0;
    repeat (2) @(negedge ref_clk);
    check({cmd_ready, scl_oe_n, sda_oe_n}, 3'b011);
    cfg.enable = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(cmd_ready, 1'b1);
    $display("disable test done");
  endtask

  task automatic t_write;
    ack_en = 1'b1;
    send(CMD_START, 8'hb4, 1'b0);
    get(0);
    check(e.kind, EV_TX_DONE);
    check({e.ack_rcvd, e.addr_phase, e.as_master, e.arb_lost}, 4'b1110);
    check({status.master, status.bus_busy, status.arb_lost}, 3'b110);
    check(got_addr, 8'hb4);
    send(CMD_WRITE, 8'hc3, 1'b0);
    get(6);
    check({e.ack_rcvd, e.addr_phase}, 2'b10);
    check(got_data, 8'hc3);
    stop_bus;
    $display("write test done");
  endtask

  task automatic t_nack;
    ack_en = 1'b0;
    send(CMD_START, 8'h78, 1'b0);
    get(0);
    check(e.ack_rcvd, 1'b0);
    stop_bus;
    $display("nack test done");
  endtask

  // Slow slave stretches the address acknowledge, then sends two bytes
  task automatic t_read;
    ack_en = 1'b1;
    stretch_ns = 3000;
    rd_byte = 8'h96;
    send(CMD_START, 8'h43, 1'b0);
    get(0);
    check(e.ack_rcvd, 1'b1);
    stretch_ns = 0;
    send(CMD_READ, 8'h00, 1'b0);
    get(0);
    check({e.kind, e.data, e.as_master}, {EV_RX_BYTE, 8'h96, 1'b1});
    send(CMD_ACK, 8'h00, 1'b1);
    send(CMD_READ, 8'h00, 1'b0);
    get(3);
    check(e.data, 8'h96);
    check(got_mack, 1'b0);
    send(CMD_ACK, 8'h00, 1'b0);
    stop_bus;
    check(got_mack, 1'b1);
    $display("read test done");
  endtask

  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    evt_ready = 1'b0;
    cfg = '{1'b1, 1'b0, 1'b0};
    ack_en = 1'b1;
    rd_byte = 8'h00;
    stretch_ns = 0;
    n_fail = 0;
    samples_checked = 0;
    t_last = 0.0;
    t_min = 1.0e9;
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({scl_oe_n, sda_oe_n, scl_out, sda_out}, 4'b1100);
    t_disable;
    t_write;
    t_nack;
    t_read;
    check(t_min >= 500.0, 1'b1);
    results;
  end
endmodule

`default_nettype wire
